// >>> hw/frcc_top.sv
// Free-running 16-bit counter with two compare channels, register port and interrupt
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

module frcc_top
   import frcc_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   // Register port
   input  wire frcc_pkg::frcc_addr_t reg_addr,
   input  wire frcc_pkg::frcc_data_t reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output frcc_pkg::frcc_data_t      reg_rdata,
   // External count clock
   input  wire logic                 ext_count_clock_in,
   // Compare outputs
   output logic                      compare_out_a,
   output logic                      compare_out_b,
   // Interrupt
   output logic                      irq
);
   import frcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   frcc_data_t free_running_count_q;
   frcc_data_t free_running_count_d;
   frcc_data_t compare_value_a_q;
   frcc_data_t compare_value_b_q;
   logic [3:0] timer_control_reg_q;
   logic [4:0] timer_ctrl_status_reg_q;
   logic [4:0] timer_ctrl_status_reg_d;
   logic [1:0] irq_mask_q;
   logic [4:0] prescale_q;
   logic       ext_clk_prev_q;
   logic       eq_a_q;
   logic       eq_b_q;
   frcc_data_t rdata_q;
   logic       out_a_q;
   logic       out_b_q;
   logic       irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding

   wire wr_count  = reg_wr && (reg_addr == FRCC_ADDR_COUNT);
   wire wr_cmp_a  = reg_wr && (reg_addr == FRCC_ADDR_CMP_A);
   wire wr_cmp_b  = reg_wr && (reg_addr == FRCC_ADDR_CMP_B);
   wire wr_ctrl   = reg_wr && (reg_addr == FRCC_ADDR_CTRL);
   wire wr_status = reg_wr && (reg_addr == FRCC_ADDR_STATUS);
   wire wr_mask   = reg_wr && (reg_addr == FRCC_ADDR_MASK);

   // Read selection, unmapped addresses read as zero
   frcc_data_t rd_sel;
   always_comb begin
      if (reg_addr == FRCC_ADDR_COUNT) begin
         rd_sel = free_running_count_q;
      end else if (reg_addr == FRCC_ADDR_CMP_A) begin
         rd_sel = compare_value_a_q;
      end else if (reg_addr == FRCC_ADDR_CMP_B) begin
         rd_sel = compare_value_b_q;
      end else if (reg_addr == FRCC_ADDR_CTRL) begin
         rd_sel = {12'h000, timer_control_reg_q};
      end else if (reg_addr == FRCC_ADDR_STATUS) begin
         rd_sel = {11'h000, timer_ctrl_status_reg_q};
      end else if (reg_addr == FRCC_ADDR_MASK) begin
         rd_sel = {14'h0000, irq_mask_q};
      end else begin
         rd_sel = 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count pulse generation

   wire [1:0] clock_select    = timer_control_reg_q[FRCC_CTRL_CLK_SEL_HI:FRCC_CTRL_CLK_SEL_LO];
   wire       clock_select_hi = clock_select[1];
   wire       clock_select_lo = clock_select[0];
   wire       ext_rise        = ext_count_clock_in && !ext_clk_prev_q;
   wire       tick_div2       = (prescale_q[0] == FRCC_PRE_DIV2[0]);
   wire       tick_div8       = (prescale_q[2:0] == FRCC_PRE_DIV8[2:0]);
   wire       tick_div32      = (prescale_q == FRCC_PRE_DIV32);

   // Four-way source selection of the count pulse
   wire count_pulse = clock_select_hi ? (clock_select_lo ? ext_rise : tick_div32)
                                      : (clock_select_lo ? tick_div8 : tick_div2);

   // Prescaler and external edge history
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prescale_q     <= 5'h00;
         ext_clk_prev_q <= 1'b0;
      end else begin
         prescale_q     <= prescale_q + 5'h01;
         ext_clk_prev_q <= ext_count_clock_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare logic

   wire eq_a      = (free_running_count_q == compare_value_a_q);
   wire eq_b      = (free_running_count_q == compare_value_b_q);
   wire match_a   = eq_a && !eq_a_q;
   wire match_b   = eq_b && !eq_b_q;
   wire clear_a   = timer_ctrl_status_reg_q[FRCC_STAT_CLEAR_A];
   wire oe_a      = timer_control_reg_q[FRCC_CTRL_OE_A];
   wire oe_b      = timer_control_reg_q[FRCC_CTRL_OE_B];
   wire level_a   = timer_ctrl_status_reg_q[FRCC_STAT_LEVEL_A];
   wire level_b   = timer_ctrl_status_reg_q[FRCC_STAT_LEVEL_B];
   wire [1:0] flags = timer_ctrl_status_reg_q[FRCC_STAT_FLAG_B:FRCC_STAT_FLAG_A];

   // Equality history so a stalled counter gives one match only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eq_a_q <= 1'b0;
         eq_b_q <= 1'b0;
      end else begin
         eq_a_q <= eq_a;
         eq_b_q <= eq_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter next value: write, then clear, then increment

   always_comb begin
      if (wr_count) begin
         free_running_count_d = reg_wdata;
      end else if (match_a && clear_a) begin
         free_running_count_d = 16'h0000;
      end else if (count_pulse) begin
         free_running_count_d = free_running_count_q + 16'h0001;
      end else begin
         free_running_count_d = free_running_count_q;
      end
   end

   // Counter and compare registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         free_running_count_q <= FRCC_COUNT_RESET;
         compare_value_a_q    <= FRCC_CMP_RESET;
         compare_value_b_q    <= FRCC_CMP_RESET;
      end else begin
         free_running_count_q <= free_running_count_d;
         if (wr_cmp_a) begin
            compare_value_a_q <= reg_wdata;
         end
         if (wr_cmp_b) begin
            compare_value_b_q <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control/status: flags set by match win over write-one-to-clear

   always_comb begin
      timer_ctrl_status_reg_d = timer_ctrl_status_reg_q;
      if (wr_status) begin
         timer_ctrl_status_reg_d[FRCC_STAT_LEVEL_A] = reg_wdata[FRCC_STAT_LEVEL_A];
         timer_ctrl_status_reg_d[FRCC_STAT_LEVEL_B] = reg_wdata[FRCC_STAT_LEVEL_B];
         timer_ctrl_status_reg_d[FRCC_STAT_CLEAR_A] = reg_wdata[FRCC_STAT_CLEAR_A];
         timer_ctrl_status_reg_d[FRCC_STAT_FLAG_A]  = flags[0] && !reg_wdata[FRCC_STAT_FLAG_A];
         timer_ctrl_status_reg_d[FRCC_STAT_FLAG_B]  = flags[1] && !reg_wdata[FRCC_STAT_FLAG_B];
      end
      if (match_a) begin
         timer_ctrl_status_reg_d[FRCC_STAT_FLAG_A] = 1'b1;
      end
      if (match_b) begin
         timer_ctrl_status_reg_d[FRCC_STAT_FLAG_B] = 1'b1;
      end
   end

   // Control, status and mask registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_control_reg_q     <= FRCC_CTRL_RESET;
         timer_ctrl_status_reg_q <= FRCC_STAT_RESET;
         irq_mask_q              <= FRCC_MASK_RESET;
      end else begin
         timer_ctrl_status_reg_q <= timer_ctrl_status_reg_d;
         if (wr_ctrl) begin
            timer_control_reg_q <= reg_wdata[3:0];
         end
         if (wr_mask) begin
            irq_mask_q <= reg_wdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pins, interrupt and read data

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         irq_q   <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         if (match_a && oe_a) begin
            out_a_q <= level_a;
         end
         if (match_b && oe_b) begin
            out_b_q <= level_b;
         end
         irq_q   <= |(timer_ctrl_status_reg_d[FRCC_STAT_FLAG_B:FRCC_STAT_FLAG_A] & irq_mask_q);
         rdata_q <= reg_rd ? rd_sel : 16'h0000;
      end
   end

   assign compare_out_a = out_a_q;
   assign compare_out_b = out_b_q;
   assign irq           = irq_q;
   assign reg_rdata     = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_count_step;
      @(posedge core_clk) disable iff (!resetn)
      (count_pulse && !reg_wr && !(match_a && clear_a)) |=>
         (free_running_count_q == $past(free_running_count_q) + 16'h0001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step");

   property p_hold_no_pulse;
      @(posedge core_clk) disable iff (!resetn)
      (!count_pulse && !reg_wr && !match_a) |=> $stable(free_running_count_q);
   endproperty
   a_hold_no_pulse: assert property (p_hold_no_pulse) else $error("counter moved without pulse");

   property p_ext_source;
      @(posedge core_clk) disable iff (!resetn)
      (clock_select == FRCC_SRC_EXT && !ext_clk_prev_q && ext_count_clock_in) |-> count_pulse;
   endproperty
   a_ext_source: assert property (p_ext_source) else $error("external edge not counted");

   property p_write_wins;
      @(posedge core_clk) disable iff (!resetn)
      wr_count |=> (free_running_count_q == $past(reg_wdata));
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("counter write lost");

   property p_clear_on_a;
      @(posedge core_clk) disable iff (!resetn)
      (match_a && clear_a && !reg_wr) |=> (free_running_count_q == 16'h0000);
   endproperty
   a_clear_on_a: assert property (p_clear_on_a) else $error("match A did not clear");

   property p_flag_a;
      @(posedge core_clk) disable iff (!resetn)
      (eq_a && !eq_a_q) |=> timer_ctrl_status_reg_q[FRCC_STAT_FLAG_A] ##1 1'b1;
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("flag A not set");

   property p_out_b;
      @(posedge core_clk) disable iff (!resetn)
      (match_b && oe_b) |=> (compare_out_b == $past(level_b));
   endproperty
   a_out_b: assert property (p_out_b) else $error("pin B not driven");

   property p_out_quiet;
      @(posedge core_clk) disable iff (!resetn)
      !(match_a && oe_a) |=> $stable(compare_out_a);
   endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("pin A changed without match");

   property p_rdata_cmp;
      @(posedge core_clk) disable iff (!resetn)
      (reg_rd && reg_addr == FRCC_ADDR_CMP_B) |=> (reg_rdata == $past(compare_value_b_q));
   endproperty
   a_rdata_cmp: assert property (p_rdata_cmp) else $error("compare B read wrong");

   property p_wrap;
      @(posedge core_clk) disable iff (!resetn)
      (free_running_count_q == 16'hffff && count_pulse && !reg_wr && !(match_a && clear_a))
         |=> (free_running_count_q == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_flag_b;
      @(posedge core_clk) disable iff (!resetn)
      match_b |=> timer_ctrl_status_reg_q[FRCC_STAT_FLAG_B];
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("flag B not set");

   property p_out_a;
      @(posedge core_clk) disable iff (!resetn)
      (match_a && oe_a) |=> (compare_out_a == $past(level_a));
   endproperty
   a_out_a: assert property (p_out_a) else $error("pin A not driven");

   property p_out_b_quiet;
      @(posedge core_clk) disable iff (!resetn)
      !(match_b && oe_b) |=> $stable(compare_out_b);
   endproperty
   a_out_b_quiet: assert property (p_out_b_quiet) else $error("pin B changed without match");

   property p_rdata_cmp_a;
      @(posedge core_clk) disable iff (!resetn)
      (reg_rd && reg_addr == FRCC_ADDR_CMP_A) |=> (reg_rdata == $past(compare_value_a_q));
   endproperty
   a_rdata_cmp_a: assert property (p_rdata_cmp_a) else $error("compare A read wrong");

   property p_rdata_count;
      @(posedge core_clk) disable iff (!resetn)
      (reg_rd && reg_addr == FRCC_ADDR_COUNT) |=> (reg_rdata == $past(free_running_count_q));
   endproperty
   a_rdata_count: assert property (p_rdata_count) else $error("counter read wrong");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (!resetn)
      !reg_rd |=> (reg_rdata == 16'h0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

   property p_cmp_write;
      @(posedge core_clk) disable iff (!resetn)
      wr_cmp_b |=> (compare_value_b_q == $past(reg_wdata));
   endproperty
   a_cmp_write: assert property (p_cmp_write) else $error("compare B write lost");

   // Interrupt follows the flags that are set and unmasked
   property p_irq_level;
      @(posedge core_clk) disable iff (!resetn)
      1'b1 |=> (irq == |(timer_ctrl_status_reg_q[FRCC_STAT_FLAG_B:FRCC_STAT_FLAG_A] & $past(irq_mask_q)));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule // frcc_top

// >>> hw/frcc_pkg.sv
// Package with constants and types of the free-running counter with compare channels
package frcc_pkg;

   // Bus widths
   typedef logic [7:0]  frcc_addr_t;
   typedef logic [15:0] frcc_data_t;

   // Clock source selection codes
   typedef enum logic [1:0] {
      FRCC_SRC_DIV2,
      FRCC_SRC_DIV8,
      FRCC_SRC_DIV32,
      FRCC_SRC_EXT
   } frcc_src_t;

   // Register word addresses
   localparam frcc_addr_t FRCC_ADDR_COUNT  = 8'h00;
   localparam frcc_addr_t FRCC_ADDR_CMP_A  = 8'h01;
   localparam frcc_addr_t FRCC_ADDR_CMP_B  = 8'h02;
   localparam frcc_addr_t FRCC_ADDR_CTRL   = 8'h03;
   localparam frcc_addr_t FRCC_ADDR_STATUS = 8'h04;
   localparam frcc_addr_t FRCC_ADDR_MASK   = 8'h05;

   // Control register field positions
   localparam int FRCC_CTRL_CLK_SEL_LO = 0;
   localparam int FRCC_CTRL_CLK_SEL_HI = 1;
   localparam int FRCC_CTRL_OE_A       = 2;
   localparam int FRCC_CTRL_OE_B       = 3;

   // Control/status register field positions
   localparam int FRCC_STAT_FLAG_A     = 0;
   localparam int FRCC_STAT_FLAG_B     = 1;
   localparam int FRCC_STAT_LEVEL_A    = 2;
   localparam int FRCC_STAT_LEVEL_B    = 3;
   localparam int FRCC_STAT_CLEAR_A    = 4;

   // Values after reset
   localparam frcc_data_t FRCC_COUNT_RESET = 16'h0000;
   localparam frcc_data_t FRCC_CMP_RESET   = 16'hffff;
   localparam logic [3:0] FRCC_CTRL_RESET  = 4'h0;
   localparam logic [4:0] FRCC_STAT_RESET  = 5'h00;
   localparam logic [1:0] FRCC_MASK_RESET  = 2'h0;

   // Prescaler terminal counts for the internal sources
   localparam logic [4:0] FRCC_PRE_DIV2  = 5'h01;
   localparam logic [4:0] FRCC_PRE_DIV8  = 5'h07;
   localparam logic [4:0] FRCC_PRE_DIV32 = 5'h1f;

endpackage : frcc_pkg

// >>> test/frcc_ext_src.sv
// External count clock source that drives the timer's count pin
`timescale 1ns/100ps

module frcc_ext_src (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Pulse request
   input  wire logic        start,
   input  wire logic [15:0] n_pulses,
   output logic             busy,
   // Count pin
   output logic             pin
);
   logic [15:0] left_q;

   // Each pulse is one cycle high and one cycle low, so the pin is low between edges; idle low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= 16'h0000;
         pin    <= 1'b0;
      end else if (start) begin
         left_q <= n_pulses;
      end else if (left_q != 16'h0000) begin
         pin <= ~pin;
         if (pin) begin
            left_q <= left_q - 16'h0001;
         end
      end
   end

   // Busy until the last pulse has fallen
   assign busy = (left_q != 16'h0000) || pin;
endmodule // frcc_ext_src

// >>> test/tb_free_running_counter_compare.sv
// Self-checking bench for the free-running counter with compare channels
`timescale 1ns/100ps

module tb_free_running_counter_compare;
   import frcc_pkg::*;

   logic       core_clk, resetn, reg_wr, reg_rd, start, busy, ext_pin, out_a, out_b, irq;
   frcc_addr_t reg_addr;
   frcc_data_t reg_wdata, reg_rdata, got, n_pulses;
   int         mismatches = 0;
   int         num_checks = 0;
   int         cycles     = 0;
   int         div[3]     = '{2, 8, 32};

   frcc_top u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_clock_in(ext_pin),
      .compare_out_a(out_a), .compare_out_b(out_b), .irq(irq));
   frcc_ext_src u_src (.core_clk(core_clk), .resetn(resetn), .start(start), .n_pulses(n_pulses),
      .busy(busy), .pin(ext_pin));

   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Whole run needs about 1000 cycles; twenty times that means a hang
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port tasks and comparisons

   task automatic wr(input frcc_addr_t a, input frcc_data_t d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input frcc_addr_t a, output frcc_data_t d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic chk(input frcc_data_t g, input frcc_data_t e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Prescaler phase is free, so a count over a window may be off by a little
   task automatic chk_near(input frcc_data_t g, input frcc_data_t e, input frcc_data_t tol);
      num_checks++;
      if ($isunknown(g) || (int'(g) > int'(e) + int'(tol)) || (int'(g) + int'(tol) < int'(e))) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic rc(input frcc_addr_t a, input frcc_data_t e);
      frcc_data_t d;
      rd(a, d);
      chk(d, e);
   endtask

   // Send n external pulses and let the last count settle
   task automatic pulse(input frcc_data_t n);
      @(posedge core_clk);
      start    <= 1'b1;
      n_pulses <= n;
      @(posedge core_clk);
      start <= 1'b0;
      #1;
      while (busy) begin
         @(posedge core_clk);
         #1;
      end
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence

   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
      start     = 1'b0;
      n_pulses  = 16'h0000;
      resetn    = 1'b0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      rd(FRCC_ADDR_COUNT, got);
      chk({got[15:2], 2'b00}, 16'h0000);
      rc(FRCC_ADDR_CMP_A, FRCC_CMP_RESET);
      rc(FRCC_ADDR_CMP_B, FRCC_CMP_RESET);
      rc(FRCC_ADDR_STATUS, 16'h0000);
      rc(FRCC_ADDR_MASK, 16'h0000);
      chk({13'h0000, irq, out_b, out_a}, 16'h0000);
      $display("test reset_values done");
      // Internal sources, window of 258 cycles
      for (int s = 0; s < 3; s++) begin
         wr(FRCC_ADDR_CTRL, frcc_data_t'(s));
         wr(FRCC_ADDR_COUNT, 16'h0000);
         repeat (256) @(posedge core_clk);
         rd(FRCC_ADDR_COUNT, got);
         chk_near(got, frcc_data_t'(258 / div[s]), 16'h0002);
      end
      wr(FRCC_ADDR_CTRL, 16'h0003);
      wr(FRCC_ADDR_COUNT, 16'h0000);
      pulse(16'h0005);
      rc(FRCC_ADDR_COUNT, 16'h0005);
      $display("test sources done");
      wr(FRCC_ADDR_COUNT, 16'h1234);
      rc(FRCC_ADDR_COUNT, 16'h1234);
      wr(FRCC_ADDR_CMP_A, 16'ha5a5);
      wr(FRCC_ADDR_CMP_B, 16'h5a5a);
      rc(FRCC_ADDR_CMP_A, 16'ha5a5);
      rc(FRCC_ADDR_CMP_B, 16'h5a5a);
      wr(8'h06, 16'hffff);
      rc(8'h06, 16'h0000);
      $display("test registers done");
      // Pass through ffff matches both channels with outputs disabled
      wr(FRCC_ADDR_CMP_A, 16'hffff);
      wr(FRCC_ADDR_CMP_B, 16'hffff);
      wr(FRCC_ADDR_COUNT, 16'hfffe);
      pulse(16'h0003);
      rc(FRCC_ADDR_COUNT, 16'h0001);
      rc(FRCC_ADDR_STATUS, 16'h0003);
      chk({13'h0000, irq, out_b, out_a}, 16'h0000);
      $display("test wrap done");
      // Enabled outputs with level one, interrupt on A only
      wr(FRCC_ADDR_STATUS, 16'h000f);
      wr(FRCC_ADDR_CTRL, 16'h000f);
      wr(FRCC_ADDR_MASK, 16'h0001);
      wr(FRCC_ADDR_CMP_A, 16'h0003);
      wr(FRCC_ADDR_CMP_B, 16'h0005);
      wr(FRCC_ADDR_COUNT, 16'h0000);
      chk({13'h0000, irq, out_b, out_a}, 16'h0000);
      pulse(16'h0003);
      chk({13'h0000, irq, out_b, out_a}, 16'h0005);
      rc(FRCC_ADDR_STATUS, 16'h000d);
      pulse(16'h0002);
      chk({13'h0000, irq, out_b, out_a}, 16'h0007);
      rc(FRCC_ADDR_STATUS, 16'h000f);
      wr(FRCC_ADDR_STATUS, 16'h000f);
      rc(FRCC_ADDR_STATUS, 16'h000c);
      chk({13'h0000, irq, out_b, out_a}, 16'h0003);
      // Level zero on A, then mask A away
      wr(FRCC_ADDR_STATUS, 16'h0003);
      wr(FRCC_ADDR_COUNT, 16'h0000);
      pulse(16'h0003);
      chk({13'h0000, irq, out_b, out_a}, 16'h0006);
      wr(FRCC_ADDR_MASK, 16'h0002);
      rc(FRCC_ADDR_STATUS, 16'h0001);
      chk({13'h0000, irq, out_b, out_a}, 16'h0002);
      $display("test compare_outputs done");
      // Clearing on match A
      wr(FRCC_ADDR_STATUS, 16'h0013);
      wr(FRCC_ADDR_COUNT, 16'h0000);
      pulse(16'h0005);
      rc(FRCC_ADDR_COUNT, 16'h0002);
      rc(FRCC_ADDR_STATUS, 16'h0011);
      $display("test clear_on_match done");
      close_out();
   end
endmodule // tb_free_running_counter_compare
